// ==== pkg/sadc_if.sv ====
interface sadc_if;
  logic cs_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  logic serial_result_lvl;

  // Line level with a weak pull-down while released
  assign serial_result_lvl = serial_result_oe & serial_result_out;

  modport dev (
    input cs_n,
    input sclk,
    output serial_result_out,
    output serial_result_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input serial_result_lvl
  );
endinterface : sadc_if

// ==== pkg/sadc_params.svh ====
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// Frame layout and edge counts
`define SADC_FRAME_BITS 5'h10
`define SADC_TRACK_EDGE 5'h0d
`define SADC_STAY_UP_EDGE 5'h0a
`define SADC_GLITCH_EDGE 5'h02
`define SADC_LEAD_ZEROS 4'h0

// Timing, in ns and in 4 ns clock cycles
`define SADC_CLK_NS 4
`define SADC_WAKE_NS 1000
`define SADC_WAKE_CYC ((`SADC_WAKE_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_RELEASE_DELAY_NS 35
`define SADC_RELEASE_DELAY_CYC (`SADC_RELEASE_DELAY_NS / `SADC_CLK_NS)
`define SADC_BUS_IDLE_GAP_NS 25
`define SADC_BUS_IDLE_GAP_CYC ((`SADC_BUS_IDLE_GAP_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_ACQ_INTERVAL_NS 200
`define SADC_ACQ_INTERVAL_CYC ((`SADC_ACQ_INTERVAL_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)

// Host serial clock divider: half period and select-to-first-clock setup
`define SADC_HALF_CYC 4'h8
`define SADC_SETUP_CYC 5'h10

// Reset values
`define SADC_RST_PD 1'b0
`define SADC_RST_UP 1'b1

`endif

// ==== pkg/sadc_pkg.sv ====
package sadc_pkg;

  // Device sequence states, Gray along idle -> conv -> done
  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_CONV = 2'h1,
    DEV_DONE = 2'h3
  } sadc_dev_e;

  // Host sequence states, Gray along idle -> setup -> clock -> gap
  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_SETUP = 2'h1,
    HST_CLK = 2'h3,
    HST_GAP = 2'h2
  } sadc_hst_e;

  typedef logic [15:0] sadc_frame_t;

endpackage : sadc_pkg

// ==== tb/sadc_properties.sv ====
module sadc_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic serial_result_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_ff;
  logic [4:0] fall_cnt_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Count serial clock falls within a frame
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_ff <= 1'b1;
      fall_cnt_ff <= 5'h00;
    end
    else
    begin
      sclk_ff <= sclk;
      if (cs_n)
        fall_cnt_ff <= 5'h00;
      else if (sclk_ff && !sclk && fall_cnt_ff != 5'h1f)
        fall_cnt_ff <= fall_cnt_ff + 5'h01;
    end
  end

  a_drive_on_fall: assert property ($fell(cs_n) |-> ##[1:4] serial_result_oe)
    else $error("data line not driven after select fall");
  a_first_zero: assert property ($rose(serial_result_oe) |-> !serial_result_lvl)
    else $error("first bit not zero");
  a_release_on_rise: assert property ($rose(cs_n) |-> ##[0:8] !serial_result_oe)
    else $error("line not released after select rise");
  a_oe_off_16th: assert property (
    (sclk_ff && !sclk && !cs_n && fall_cnt_ff == 5'h0f) |-> ##[1:5] !serial_result_oe)
    else $error("line not released after last fall");
  a_oe_end_cause: assert property (
    $fell(serial_result_oe) |-> (cs_n || fall_cnt_ff == 5'h10))
    else $error("line released mid frame");
  a_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("serial clock not idle high");
  a_sclk_setup: assert property ($fell(cs_n) |-> sclk [*8])
    else $error("serial clock too soon after select");
  a_data_stable: assert property (
    (serial_result_oe && $past(serial_result_oe) && sclk && $past(sclk, 4))
      |-> $stable(serial_result_out))
    else $error("data changed while clock high");
  a_idle_gap: assert property (
    $fell(cs_n) |-> (!$past(serial_result_oe, 1) && !$past(serial_result_oe, 7)))
    else $error("select fell inside idle gap");
endmodule : sadc_properties

// ==== tb/test_sar_adc_serial_readout_power_modes.sv ====
`define CHK(g, e) check_val(16'(g), 16'(e))

module test_sar_adc_serial_readout_power_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_resetn, i_start, i_rise_capture, i_word_ready;
  logic [4:0] i_burst;
  logic [11:0] i_analog_code, o_conv_code;
  logic o_hold, o_analog_on, o_fully_up, o_power_down, o_conv_valid, o_conv_done;
  int n_done = 0;
  logic o_start_ready, o_busy, o_word_valid, sclk_q, cs_q;
  logic [15:0] o_word, w, mon;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [4:0] bursts [7] = '{5'h01, 5'h05, 5'h09, 5'h0a, 5'h0c, 5'h02, 5'h10};
  logic pds [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  sadc_if link();
  sadc_device sadc_device_inst (.i_clk(i_clk), .i_resetn(i_resetn), .bus(link),
    .i_analog_code(i_analog_code), .o_hold(o_hold), .o_analog_on(o_analog_on),
    .o_fully_up(o_fully_up), .o_power_down(o_power_down), .o_conv_done(o_conv_done),
    .o_conv_valid(o_conv_valid), .o_conv_code(o_conv_code));
  sadc_host sadc_host_inst (.i_clk(i_clk), .i_resetn(i_resetn), .bus(link),
    .i_start(i_start), .i_burst(i_burst), .i_rise_capture(i_rise_capture),
    .o_start_ready(o_start_ready), .o_busy(o_busy), .o_word(o_word),
    .o_word_valid(o_word_valid), .i_word_ready(i_word_ready));
  sadc_properties sadc_properties_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .cs_n(link.cs_n), .sclk(link.sclk), .serial_result_out(link.serial_result_out),
    .serial_result_oe(link.serial_result_oe), .serial_result_lvl(link.serial_result_lvl));

  // Clock
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Wire monitor: bits seen at each serial clock fall
  always @(posedge i_clk)
  begin
    sclk_q <= link.sclk;
    cs_q <= link.cs_n;
    if (cs_q && !link.cs_n)
      mon <= 16'h0000;
    else if (sclk_q && !link.sclk)
      mon <= {mon[14:0], link.serial_result_lvl};
  end

  // Hang guard and count of completed conversions
  always @(posedge i_clk)
  begin
    cycles++;
    if (o_conv_done === 1'b1)
      n_done++;
    if (cycles > 20000)
    begin
      fails++;
      close_out();
    end
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // One frame request, waits for the host to go idle
  task automatic frame(input logic [4:0] b, input logic r, input logic [11:0] c);
    int k;
    @(negedge i_clk);
    i_burst = b;
    i_rise_capture = r;
    i_analog_code = c;
    k = 0;
    while (o_start_ready !== 1'b1 && k < 1000)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 1000)
      fails++;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    k = 0;
    while (o_busy !== 1'b0 && k < 2000)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 2000)
      fails++;
  endtask : frame

  // Take one received word
  task automatic pop(output logic [15:0] v);
    int k;
    k = 0;
    while (o_word_valid !== 1'b1 && k < 100)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 100)
      fails++;
    v = o_word;
    i_word_ready = 1'b1;
    @(negedge i_clk);
    i_word_ready = 1'b0;
  endtask : pop

  // Main sequence
  initial
  begin
    i_resetn = 1'b0;
    i_start = 1'b0;
    i_burst = 5'h10;
    i_rise_capture = 1'b0;
    i_word_ready = 1'b0;
    i_analog_code = 12'h000;
    repeat (5) @(negedge i_clk);
    i_resetn = 1'b1;
    // Let the checker's history fill with reset values before the first select fall
    repeat (2) @(negedge i_clk);
    frame(5'h10, 1'b0, 12'ha5c);
    `CHK(mon, 16'h0a5c);
    `CHK(link.serial_result_oe, 1'b0);
    `CHK(o_conv_code, 12'ha5c);
    `CHK(o_hold, 1'b0);
    pop(w);
    `CHK(w, 16'h0a5c);
    frame(5'h12, 1'b0, 12'h3c1);
    pop(w);
    `CHK(w, 16'h03c1);
    frame(5'h10, 1'b1, 12'h7e9);
    pop(w);
    `CHK(w, 16'h07e9);
    for (int i = 0; i < 7; i++)
    begin
      frame(bursts[i], 1'b0, 12'h111);
      `CHK(o_power_down, pds[i]);
      `CHK(o_analog_on, !pds[i]);
      if (bursts[i] < 5'h10)
        `CHK(o_word_valid, 1'b0);
    end
    pop(w);
    `CHK(o_fully_up, 1'b1);
    frame(5'h10, 1'b0, 12'h5a3);
    `CHK(o_conv_valid, 1'b1);
    pop(w);
    frame(5'h10, 1'b0, 12'h001);
    frame(5'h10, 1'b0, 12'hfff);
    @(negedge i_clk);
    `CHK(o_start_ready, 1'b0);
    pop(w);
    `CHK(w, 16'h0001);
    pop(w);
    `CHK(w, 16'h0fff);
    `CHK(o_word_valid, 1'b0);
    `CHK(n_done, 7);
    close_out();
  end
endmodule : test_sar_adc_serial_readout_power_modes

// ==== verilog/sadc_device.sv ====
`include "sadc_params.svh"

module sadc_device (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Serial link
  sadc_if.dev bus,
  // Converter core
  input wire logic [11:0] i_analog_code,
  output logic o_hold,
  output logic o_analog_on,
  output logic o_fully_up,
  output logic o_power_down,
  // Conversion result
  output logic o_conv_done,
  output logic o_conv_valid,
  output logic [11:0] o_conv_code
);

  // All state of the device end
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    sadc_pkg::sadc_dev_e state;
    logic [4:0] fcnt;
    sadc_pkg::sadc_frame_t shreg;
    logic oe;
    logic hold;
    logic pd;
    logic waking;
    logic first_edge;
    logic track_pend;
    logic up;
    logic [7:0] wake_cnt;
    logic smp_up;
    logic done;
    logic valid;
    logic [11:0] code;
  } sadc_dev_s;

  localparam logic [7:0] WAKE_LAST = 8'(`SADC_WAKE_CYC - 1);

  localparam sadc_dev_s RST = '{
    cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
    ck_s1: 1'b1, ck_s2: 1'b1, ck_s3: 1'b1,
    state: sadc_pkg::DEV_IDLE,
    fcnt: 5'h0,
    shreg: 16'h0000,
    oe: 1'b0,
    hold: 1'b0,
    pd: `SADC_RST_PD,
    waking: 1'b0,
    first_edge: 1'b0,
    track_pend: 1'b0,
    up: `SADC_RST_UP,
    wake_cnt: 8'h00,
    smp_up: 1'b0,
    done: 1'b0,
    valid: 1'b0,
    code: 12'h000
  };

  sadc_dev_s q_ff;
  sadc_dev_s nxt_q;

  logic cs_fall;
  logic cs_rise;
  logic ck_fall;
  logic ck_rise;

  // Mode after a select rise, from the falls seen so far
  function automatic logic next_pd(input logic pd, input logic [4:0] falls);
    logic r;
    r = pd;
    if (falls >= `SADC_STAY_UP_EDGE)
    begin
      r = 1'b0;
    end
    else if (falls >= `SADC_GLITCH_EDGE)
    begin
      r = 1'b1;
    end
    return r;
  endfunction : next_pd

  // Edge detection on the second and third sync stages
  assign cs_fall = q_ff.cs_s3 & ~q_ff.cs_s2;
  assign cs_rise = ~q_ff.cs_s3 & q_ff.cs_s2;
  assign ck_fall = q_ff.ck_s3 & ~q_ff.ck_s2;
  assign ck_rise = ~q_ff.ck_s3 & q_ff.ck_s2;

  // Next-state logic
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.cs_s1 = bus.cs_n;
    nxt_q.cs_s2 = q_ff.cs_s1;
    nxt_q.cs_s3 = q_ff.cs_s2;
    nxt_q.ck_s1 = bus.sclk;
    nxt_q.ck_s2 = q_ff.ck_s1;
    nxt_q.ck_s3 = q_ff.ck_s2;
    nxt_q.done = 1'b0;

    // Power-up timer runs while analog is on and not yet settled
    if ((q_ff.waking || !q_ff.pd) && !q_ff.up)
    begin
      if (q_ff.wake_cnt == WAKE_LAST)
      begin
        nxt_q.up = 1'b1;
      end
      else
      begin
        nxt_q.wake_cnt = q_ff.wake_cnt + 8'h01;
      end
    end

    unique case (q_ff.state)
      sadc_pkg::DEV_IDLE:
      begin
        if (cs_fall)
        begin
          nxt_q.state = sadc_pkg::DEV_CONV;
          nxt_q.fcnt = 5'h0;
          nxt_q.shreg = {`SADC_LEAD_ZEROS, i_analog_code};
          nxt_q.oe = 1'b1;
          nxt_q.hold = 1'b1;
          nxt_q.code = i_analog_code;
          nxt_q.smp_up = q_ff.up;
          nxt_q.track_pend = 1'b0;
          nxt_q.first_edge = q_ff.pd;
          nxt_q.waking = q_ff.pd;
        end
      end
      sadc_pkg::DEV_CONV:
      begin
        if (cs_rise)
        begin
          // Abort before the sixteenth fall
          nxt_q.state = sadc_pkg::DEV_IDLE;
          nxt_q.oe = 1'b0;
          nxt_q.waking = 1'b0;
          nxt_q.track_pend = 1'b0;
          nxt_q.first_edge = 1'b0;
          nxt_q.pd = next_pd(q_ff.pd, q_ff.fcnt);
          // Powered-down core stays in hold
          nxt_q.hold = next_pd(q_ff.pd, q_ff.fcnt);
          if (next_pd(q_ff.pd, q_ff.fcnt))
          begin
            nxt_q.up = 1'b0;
            nxt_q.wake_cnt = 8'h00;
          end
        end
        else
        begin
          // Waking core tracks on the first edge of either kind
          if ((ck_rise || ck_fall) && q_ff.first_edge)
          begin
            nxt_q.hold = 1'b0;
            nxt_q.first_edge = 1'b0;
          end
          if (ck_rise && q_ff.track_pend)
          begin
            nxt_q.hold = 1'b0;
            nxt_q.track_pend = 1'b0;
          end
          if (ck_fall)
          begin
            nxt_q.fcnt = q_ff.fcnt + 5'h01;
            nxt_q.shreg = {q_ff.shreg[14:0], 1'b0};
            if (q_ff.fcnt + 5'h01 == `SADC_TRACK_EDGE)
            begin
              nxt_q.track_pend = 1'b1;
            end
            if (q_ff.fcnt + 5'h01 == `SADC_FRAME_BITS)
            begin
              nxt_q.state = sadc_pkg::DEV_DONE;
              nxt_q.oe = 1'b0;
              nxt_q.done = 1'b1;
              nxt_q.valid = q_ff.smp_up;
            end
          end
        end
      end
      sadc_pkg::DEV_DONE:
      begin
        // Full frame: rise confirms normal mode
        if (cs_rise)
        begin
          nxt_q.state = sadc_pkg::DEV_IDLE;
          nxt_q.pd = next_pd(q_ff.pd, q_ff.fcnt);
          nxt_q.waking = 1'b0;
          nxt_q.first_edge = 1'b0;
        end
      end
      default:
      begin
        nxt_q.state = sadc_pkg::DEV_IDLE;
        nxt_q.oe = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q_ff <= RST;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // Link and core outputs
  assign bus.serial_result_out = q_ff.shreg[15];
  assign bus.serial_result_oe = q_ff.oe;
  assign o_hold = q_ff.hold;
  assign o_analog_on = ~q_ff.pd | q_ff.waking;
  assign o_fully_up = q_ff.up & ~q_ff.pd;
  assign o_power_down = q_ff.pd;
  assign o_conv_done = q_ff.done;
  assign o_conv_valid = q_ff.valid;
  assign o_conv_code = q_ff.code;

endmodule : sadc_device

// ==== verilog/sadc_host.sv ====
`include "sadc_params.svh"

module sadc_host (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Serial link
  sadc_if.host bus,
  // Frame request
  input wire logic i_start,
  input wire logic [4:0] i_burst,
  input wire logic i_rise_capture,
  output logic o_start_ready,
  output logic o_busy,
  // Received words
  output logic [15:0] o_word,
  output logic o_word_valid,
  input wire logic i_word_ready
);

  // All state of the host end
  typedef struct packed {
    sadc_pkg::sadc_hst_e state;
    logic cs_n;
    logic sclk;
    logic [4:0] div;
    logic [4:0] falls;
    logic [4:0] burst;
    logic rise_mode;
    sadc_pkg::sadc_frame_t shreg;
    logic [7:0] gap;
    logic sd_s1;
    logic sd_s2;
    logic [1:0][15:0] mem;
    logic wptr;
    logic rptr;
    logic [1:0] cnt;
  } sadc_hst_s;

  localparam logic [7:0] GAP_LAST = 8'(`SADC_ACQ_INTERVAL_CYC + `SADC_BUS_IDLE_GAP_CYC
    + `SADC_RELEASE_DELAY_CYC - 1);

  sadc_hst_s q_ff;
  sadc_hst_s nxt_q;
  logic pop;
  logic push;

  assign o_start_ready = (q_ff.state == sadc_pkg::HST_IDLE) && (q_ff.cnt != 2'h2);
  assign pop = o_word_valid & i_word_ready;

  // Next-state logic
  always_comb
  begin
    nxt_q = q_ff;
    push = 1'b0;
    nxt_q.sd_s1 = bus.serial_result_lvl;
    nxt_q.sd_s2 = q_ff.sd_s1;
    unique case (q_ff.state)
      sadc_pkg::HST_IDLE:
      begin
        // Full buffer stalls new frames
        if (i_start && o_start_ready)
        begin
          nxt_q.state = sadc_pkg::HST_SETUP;
          nxt_q.cs_n = 1'b0;
          nxt_q.div = 5'h0;
          nxt_q.falls = 5'h0;
          nxt_q.burst = i_burst;
          nxt_q.rise_mode = i_rise_capture;
          nxt_q.shreg = 16'h0000;
        end
      end
      sadc_pkg::HST_SETUP:
      begin
        // Select-to-first-clock setup, then first fall
        nxt_q.div = q_ff.div + 5'h01;
        if (q_ff.div == `SADC_SETUP_CYC - 5'h01)
        begin
          nxt_q.state = sadc_pkg::HST_CLK;
          nxt_q.div = 5'h0;
          nxt_q.sclk = 1'b0;
          nxt_q.falls = 5'h01;
          if (!q_ff.rise_mode)
          begin
            nxt_q.shreg = {q_ff.shreg[14:0], q_ff.sd_s2};
          end
        end
      end
      sadc_pkg::HST_CLK:
      begin
        nxt_q.div = q_ff.div + 5'h01;
        if (q_ff.div == {1'b0, `SADC_HALF_CYC} - 5'h01)
        begin
          nxt_q.div = 5'h0;
          nxt_q.sclk = ~q_ff.sclk;
          if (!q_ff.sclk)
          begin
            // Rising edge: slow-clock capture of bits 1..15
            if (q_ff.rise_mode && q_ff.falls < `SADC_FRAME_BITS)
            begin
              nxt_q.shreg = {q_ff.shreg[14:0], q_ff.sd_s2};
            end
            if (q_ff.falls == q_ff.burst)
            begin
              nxt_q.state = sadc_pkg::HST_GAP;
              nxt_q.cs_n = 1'b1;
              nxt_q.gap = 8'h00;
              push = q_ff.falls >= `SADC_FRAME_BITS;
            end
          end
          else
          begin
            // Falling edge: capture the bit standing at this edge
            nxt_q.falls = q_ff.falls + 5'h01;
            if (!q_ff.rise_mode && q_ff.falls < `SADC_FRAME_BITS)
            begin
              nxt_q.shreg = {q_ff.shreg[14:0], q_ff.sd_s2};
            end
          end
        end
      end
      sadc_pkg::HST_GAP:
      begin
        // Acquisition, release and idle gap before next select fall
        nxt_q.gap = q_ff.gap + 8'h01;
        if (q_ff.gap == GAP_LAST)
        begin
          nxt_q.state = sadc_pkg::HST_IDLE;
        end
      end
    endcase
    // Two-entry word buffer
    if (push)
    begin
      nxt_q.mem[q_ff.wptr] = q_ff.shreg;
      nxt_q.wptr = ~q_ff.wptr;
    end
    if (pop)
    begin
      nxt_q.rptr = ~q_ff.rptr;
    end
    nxt_q.cnt = q_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q_ff <= '{state: sadc_pkg::HST_IDLE, cs_n: 1'b1, sclk: 1'b1, default: '0};
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign bus.cs_n = q_ff.cs_n;
  assign bus.sclk = q_ff.sclk;
  assign o_busy = q_ff.state != sadc_pkg::HST_IDLE;
  assign o_word = q_ff.mem[q_ff.rptr];
  assign o_word_valid = q_ff.cnt != 2'h0;

endmodule : sadc_host
